// file: bench/meim_event_irq_tb.sv
`timescale 1ns/1ps
module meim_event_irq_tb;
    localparam logic [19:0] A_ST = {2'h0, meim_pkg::IDX_STATUS, 2'h0};
    localparam logic [19:0] A_MK = {2'h0, meim_pkg::IDX_EVENT_IRQ_ENABLE_0, 2'h0};
    localparam logic [19:0] A_PM = {2'h0, meim_pkg::IDX_PULSE_MODE, 2'h0};
    localparam logic [19:0] A_AM = {2'h0, meim_pkg::IDX_ACCUM_MODE, 2'h0};
    localparam logic [19:0] A_RN = {2'h0, meim_pkg::IDX_RUN, 2'h0};
    localparam logic [19:0] A_VP = {2'h0, meim_pkg::IDX_VOLT_PEAK_VALUE_REG, 2'h0};

    logic        sys_clk, reset, psel, penable, pwrite, pready, pslverr, irq_request_n;
    logic [19:0] paddr;
    logic [31:0] pwdata, prdata, volt_peak_value, cfg_checksum, q_data;
    logic [2:0]  ta_b30, fa_b30, fr_b30, ap_b30, ta_sg, fa_sg, fr_sg, pulse_raw_n;
    logic [2:0]  sel1, sel2, sel3;
    logic        line_cycle_done, p1_sg, p2_sg, dsp_pass_done, volt_peak_period_done;
    logic        out1, out2, out3, q_err;
    int          fails, check_count;

    meim_event_irq i_meim_event_irq (
        .sys_clk                 (sys_clk),
        .reset                   (reset),
        .psel                    (psel),
        .penable                 (penable),
        .pwrite                  (pwrite),
        .paddr                   (paddr),
        .pwdata                  (pwdata),
        .prdata                  (prdata),
        .pready                  (pready),
        .pslverr                 (pslverr),
        .total_active_acc_bit30  (ta_b30),
        .fund_active_acc_bit30   (fa_b30),
        .fund_reactive_acc_bit30 (fr_b30),
        .apparent_acc_bit30      (ap_b30),
        .line_cycle_done         (line_cycle_done),
        .total_active_sign       (ta_sg),
        .fund_active_sign        (fa_sg),
        .fund_reactive_sign      (fr_sg),
        .path1_sum_sign          (p1_sg),
        .path2_sum_sign          (p2_sg),
        .pulse_raw_n             (pulse_raw_n),
        .dsp_pass_done           (dsp_pass_done),
        .volt_peak_period_done   (volt_peak_period_done),
        .volt_peak_value         (volt_peak_value),
        .cfg_checksum            (cfg_checksum),
        .irq_request_n           (irq_request_n),
        .pulse_out_first         (out1),
        .pulse_out_second        (out2),
        .pulse_out_third         (out3),
        .pulse_first_power_sel   (sel1),
        .pulse_second_power_sel  (sel2),
        .pulse_third_power_sel   (sel3)
    );

    // 20 MHz core clock
    always #25 sys_clk = ~sys_clk;

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            $display("BAD %s expected %h seen %h", name, exp, got);
            fails++;
        end
    endtask

    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [19:0] a, input logic [31:0] d);
        int n;
        @(posedge sys_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) fails++;
        q_data = prdata;
        q_err  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [19:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input string name, input logic [19:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(name, exp, q_data);
    endtask

    // one event of the given status position; levels toggle, pulses last one cycle
    task automatic fire(input int b);
        case (b)
            0: ta_b30[0] <= ~ta_b30[0];
            1: fa_b30[1] <= ~fa_b30[1];
            3: fr_b30[2] <= ~fr_b30[2];
            4: ap_b30[0] <= ~ap_b30[0];
            5: line_cycle_done <= 1'b1;
            6, 7, 8: ta_sg <= ta_sg ^ (3'h1 << (b - 6));
            9: p1_sg <= ~p1_sg;
            10, 11, 12: fr_sg <= fr_sg ^ (3'h1 << (b - 10));
            13: p2_sg <= ~p2_sg;
            14, 15, 16: pulse_raw_n <= ~(3'h1 << (b - 14));
            17: dsp_pass_done <= 1'b1;
            18: fa_sg[1] <= ~fa_sg[1];
            default: ;
        endcase
        @(posedge sys_clk);
        line_cycle_done <= 1'b0;
        dsp_pass_done   <= 1'b0;
        pulse_raw_n     <= 3'h7;
        repeat (3) @(posedge sys_clk);
    endtask

    task automatic t_reset;
        rd("event_irq_enable_0", A_MK, meim_pkg::EVENT_IRQ_ENABLE_0_RST);
        rd("status", A_ST, meim_pkg::STATUS_RST);
        rd("pulse mode", A_PM, meim_pkg::PULSE_MODE_RST);
        chk("irq", 32'h1, {31'h0, irq_request_n});
        rd("unmapped", 20'h00004, 32'h0);
        chk("slverr", 32'h1, {31'h0, q_err});
        rd("misaligned", A_MK + 20'h1, 32'h0);
        chk("slverr", 32'h1, {31'h0, q_err});
        $display("reset test done");
    endtask

    // flag sets with mask off; enabling the mask later raises the request
    task automatic t_mask;
        wr(A_MK, 32'h0000_0004);
        fire(17);
        chk("irq", 32'h1, {31'h0, irq_request_n});
        rd("status", A_ST, 32'h0002_0000);
        wr(A_MK, 32'h0002_0000);
        repeat (3) @(posedge sys_clk);
        chk("irq", 32'h0, {31'h0, irq_request_n});
        wr(A_ST, 32'h0002_0000);
        repeat (3) @(posedge sys_clk);
        chk("irq", 32'h1, {31'h0, irq_request_n});
        $display("mask test done");
    endtask

    // line event ignored outside line mode; sign source chosen by mode bit 6
    task automatic t_mode;
        wr(A_AM, 32'h0);
        fire(5);
        rd("status", A_ST, 32'h0);
        wr(A_AM, 32'h40);
        repeat (3) @(posedge sys_clk);
        wr(A_ST, 32'hffff_ffff);
        fire(6);
        rd("status", A_ST, 32'h0);
        fire(18);
        rd("status", A_ST, 32'h0000_0080);
        wr(A_ST, 32'hffff_ffff);
        $display("mode test done");
    endtask

    task automatic t_events;
        wr(A_AM, 32'h80);
        wr(A_MK, 32'hffff_ffff);
        rd("event_irq_enable_0", A_MK, meim_pkg::EVENT_IRQ_ENABLE_0_IMPL);
        repeat (3) @(posedge sys_clk);
        wr(A_ST, 32'hffff_ffff);
        for (int b = 0; b < 18; b++) begin
            if (b == 2) continue;
            fire(b);
            chk("irq", 32'h0, {31'h0, irq_request_n});
            rd("status", A_ST, 32'h1 << b);
            wr(A_ST, 32'h1 << b);
            repeat (3) @(posedge sys_clk);
            chk("irq", 32'h1, {31'h0, irq_request_n});
        end
        $display("event test done");
    endtask

    // disabled first output still flags; second output follows the raw pulse
    task automatic t_pulse;
        wr(A_PM, 32'h0000_02d1);
        rd("pulse mode", A_PM, 32'h0000_02d1);
        chk("sels", 32'h0d1, {23'h0, sel3, sel2, sel1});
        pulse_raw_n <= 3'h4;
        repeat (2) @(posedge sys_clk);
        chk("out1", 32'h1, {31'h0, out1});
        chk("out2", 32'h0, {31'h0, out2});
        chk("out3", 32'h1, {31'h0, out3});
        pulse_raw_n <= 3'h7;
        repeat (3) @(posedge sys_clk);
        rd("status", A_ST, 32'h0000_c000);
        wr(A_ST, 32'h0000_c000);
        $display("pulse test done");
    endtask

    task automatic t_peak;
        volt_peak_value       <= 32'h1234_5678;
        volt_peak_period_done <= 1'b1;
        @(posedge sys_clk);
        volt_peak_period_done <= 1'b0;
        repeat (3) @(posedge sys_clk);
        rd("status", A_ST, 32'h0100_0000);
        rd("peak", A_VP, 32'h1234_5678);
        wr(A_ST, 32'hff00_0000);
        wr(A_RN, 32'h1);
        rd("status", A_ST, 32'h0);
        // restart the run and move the checksum right after, so the run-start check is reached
        wr(A_RN, 32'h1);
        cfg_checksum <= 32'h0000_005a;
        repeat (3) @(posedge sys_clk);
        rd("status", A_ST, 32'h0200_0000);
        wr(A_RN, 32'h0);
        wr(A_ST, 32'h0200_0000);
        rd("status", A_ST, 32'h0);
        $display("peak test done");
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial begin
        sys_clk = 0;
        reset = 1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {ta_b30, fa_b30, fr_b30, ap_b30, ta_sg, fa_sg, fr_sg} = '0;
        {line_cycle_done, p1_sg, p2_sg, dsp_pass_done, volt_peak_period_done} = '0;
        pulse_raw_n = 3'h7;
        volt_peak_value = 32'h0;
        cfg_checksum = 32'h0000_00a5;
        fails = 0;
        check_count = 0;
        repeat (6) @(posedge sys_clk);
        reset <= 1'b0;
        t_reset();
        t_mask();
        t_mode();
        t_events();
        t_pulse();
        t_peak();
        report_and_stop();
    end

    // the whole run needs well under 2000 cycles
    initial begin
        #1000000;
        fails++;
        report_and_stop();
    end
endmodule

// file: hdl/meim_apb_port.sv
`timescale 1ns/1ps
module meim_apb_port (
    input  wire logic        sys_clk,
    input  wire logic        reset,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [19:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    meim_reg_if.front        bus
);
    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } meim_apb_s;

    meim_apb_s st;
    meim_apb_s next_st;

    // read data is caught in the setup cycle so the answer is one access cycle
    always_comb begin
        next_st = st;
        next_st.pready = 1'b0;
        next_st.pslverr = 1'b0;
        if (psel && !penable) begin
            next_st.pready = 1'b1;
            next_st.pslverr = !bus.hit;
            next_st.prdata = (bus.hit && !pwrite) ? bus.rdata : 32'h0000_0000;
        end
    end

    // write strobe only at the edge that completes the access
    assign bus.idx = meim_pkg::idx_of(paddr);
    assign bus.wdata = pwdata;
    assign bus.wr = psel && penable && st.pready && pwrite && !st.pslverr;
    assign prdata = st.prdata;
    assign pready = st.pready;
    assign pslverr = st.pslverr;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule

// file: hdl/meim_chg_det.sv
`timescale 1ns/1ps
module meim_chg_det #(
    parameter int unsigned W         = 1,
    parameter bit          FALL_ONLY = 1'b0
) (
    input  wire logic         sys_clk,
    input  wire logic         reset,
    input  wire logic [W-1:0] level,
    output logic      [W-1:0] evt
);
    typedef struct packed {
        logic [W-1:0] prev;
        logic         primed;
    } meim_chg_s;

    meim_chg_s st;
    meim_chg_s next_st;

    // first sample after reset only primes, so no event appears from reset alone
    always_comb begin
        next_st.prev = level;
        next_st.primed = 1'b1;
    end

    assign evt = !st.primed ? '0 :
                 FALL_ONLY ? (st.prev & ~level) : (st.prev ^ level);

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule

// file: hdl/meim_event_irq.sv
`timescale 1ns/1ps
// Overview of operation
// - When the voltage peak period ends, status bit 24 sets and the peak value is held.
// - Status bit 25 sets when the live checksum differs from the one caught at run start.
// - Status bits 31 to 26 always read as zero.
// - Mask bits 0, 1, 3, 4 enable events on any bit-30 change of the four energy kinds.
// - Mask bit 2 has no effect on the interrupt.
// - In line-cycle mode, mask bit 5 enables the half-cycle integration done event.
// - Mask bits 6 to 8 enable phase active power sign changes, source picked by mode bit 6.
// - Mask bits 9 and 13 enable sign changes of the first and second path power sums.
// - Mask bits 10 to 12 enable sign changes of phase fundamental reactive power.
// - Mask bits 14 to 16 enable events on falling edges of the three raw pulse inputs, disabled pins included.
// - Pulse power type comes from three 3-bit fields of the pulse mode register.
// - Mask bit 17 enables the periodic dsp pass done event.
// - A pending enabled event drives the active-low interrupt pin low.
module meim_event_irq (
    input  wire logic        sys_clk,
    input  wire logic        reset,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [19:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [2:0]  total_active_acc_bit30,
    input  wire logic [2:0]  fund_active_acc_bit30,
    input  wire logic [2:0]  fund_reactive_acc_bit30,
    input  wire logic [2:0]  apparent_acc_bit30,
    input  wire logic        line_cycle_done,
    input  wire logic [2:0]  total_active_sign,
    input  wire logic [2:0]  fund_active_sign,
    input  wire logic [2:0]  fund_reactive_sign,
    input  wire logic        path1_sum_sign,
    input  wire logic        path2_sum_sign,
    input  wire logic [2:0]  pulse_raw_n,
    input  wire logic        dsp_pass_done,
    input  wire logic        volt_peak_period_done,
    input  wire logic [31:0] volt_peak_value,
    input  wire logic [31:0] cfg_checksum,
    output logic             irq_request_n,
    output logic             pulse_out_first,
    output logic             pulse_out_second,
    output logic             pulse_out_third,
    output logic      [2:0]  pulse_first_power_sel,
    output logic      [2:0]  pulse_second_power_sel,
    output logic      [2:0]  pulse_third_power_sel
);
    typedef struct packed {
        logic [31:0] status;
        logic [31:0] event_irq_enable_0;
        logic [31:0] pulse_mode_reg;
        logic [31:0] accumulation_mode_reg;
        logic        run;
        logic [31:0] crc_ref;
        logic [31:0] volt_peak_value_reg;
        logic        irq_n;
        logic [2:0]  pulse_pin;
    } meim_state_s;

    meim_state_s st;
    meim_state_s next_st;
    meim_reg_if  bus ();

    logic [19:0] chg_level;
    logic [19:0] chg_evt;
    logic [2:0]  fall_evt;
    logic [2:0]  act_sign_sel;
    logic [31:0] set_vec;
    logic [31:0] clr_vec;
    logic [31:0] pending;
    logic        wr_status;

    meim_apb_port u_apb (
        .sys_clk (sys_clk),
        .reset   (reset),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pwdata  (pwdata),
        .prdata  (prdata),
        .pready  (pready),
        .pslverr (pslverr),
        .bus     (bus.front)
    );

    // a flip of the source select looks like a sign change; software should clear after
    assign act_sign_sel = st.accumulation_mode_reg[meim_pkg::AM_SIGN_SEL] ?
                          fund_active_sign : total_active_sign;

    // level changes: energy bit 30 of each phase and every watched sign
    assign chg_level = {path2_sum_sign, path1_sum_sign, fund_reactive_sign, act_sign_sel,
                        apparent_acc_bit30, fund_reactive_acc_bit30,
                        fund_active_acc_bit30, total_active_acc_bit30};

    meim_chg_det #(
        .W         (20),
        .FALL_ONLY (1'b0)
    ) u_chg (
        .sys_clk (sys_clk),
        .reset   (reset),
        .level   (chg_level),
        .evt     (chg_evt)
    );

    // watches the pulse levels before the pin disable, so disabled pins still count
    meim_chg_det #(
        .W         (3),
        .FALL_ONLY (1'b1)
    ) u_fall (
        .sys_clk (sys_clk),
        .reset   (reset),
        .level   (pulse_raw_n),
        .evt     (fall_evt)
    );

    // event set vector, one bit per status flag
    always_comb begin
        set_vec = 32'h0000_0000;
        set_vec[meim_pkg::EB_TOTAL_ACT] = |chg_evt[2:0];
        set_vec[meim_pkg::EB_FUND_ACT] = |chg_evt[5:3];
        set_vec[meim_pkg::EB_FUND_REACT] = |chg_evt[8:6];
        set_vec[meim_pkg::EB_APPARENT] = |chg_evt[11:9];
        set_vec[meim_pkg::EB_LINE] = line_cycle_done &&
                                     st.accumulation_mode_reg[meim_pkg::AM_LINE_MODE];
        set_vec[meim_pkg::EB_ACT_SIGN +: 3] = chg_evt[14:12];
        set_vec[meim_pkg::EB_REACT_SIGN +: 3] = chg_evt[17:15];
        set_vec[meim_pkg::EB_SUM1] = chg_evt[18];
        set_vec[meim_pkg::EB_SUM2] = chg_evt[19];
        set_vec[meim_pkg::EB_PULSE +: 3] = fall_evt;
        set_vec[meim_pkg::EB_DSP] = dsp_pass_done;
        set_vec[meim_pkg::EB_PEAK_V] = volt_peak_period_done;
        set_vec[meim_pkg::EB_CRC] = st.run && (cfg_checksum != st.crc_ref);
    end

    // write-one-to-clear; a set in the same cycle wins
    assign wr_status = bus.wr && (bus.idx == meim_pkg::IDX_STATUS);
    assign clr_vec = wr_status ? bus.wdata : 32'h0000_0000;
    assign pending = st.status & st.event_irq_enable_0 & meim_pkg::EVENT_IRQ_ENABLE_0_IRQ;

    // register read decode; unimplemented bits read zero
    always_comb begin
        bus.hit = 1'b1;
        case (bus.idx)
            meim_pkg::IDX_STATUS: begin
                bus.rdata = st.status;
            end
            meim_pkg::IDX_EVENT_IRQ_ENABLE_0: begin
                bus.rdata = st.event_irq_enable_0;
            end
            meim_pkg::IDX_PULSE_MODE: begin
                bus.rdata = st.pulse_mode_reg;
            end
            meim_pkg::IDX_ACCUM_MODE: begin
                bus.rdata = st.accumulation_mode_reg;
            end
            meim_pkg::IDX_RUN: begin
                bus.rdata = {31'h0000_0000, st.run};
            end
            meim_pkg::IDX_VOLT_PEAK_VALUE_REG: begin
                bus.rdata = st.volt_peak_value_reg;
            end
            default: begin
                bus.hit = 1'b0;
                bus.rdata = 32'h0000_0000;
            end
        endcase
    end

    // next state: flags, control registers, checksum reference, pins
    always_comb begin
        next_st = st;
        next_st.status = ((st.status & ~clr_vec) | set_vec) & meim_pkg::STATUS_IMPL;
        if (volt_peak_period_done) begin
            next_st.volt_peak_value_reg = volt_peak_value;
        end
        if (bus.wr) begin
            case (bus.idx)
                meim_pkg::IDX_EVENT_IRQ_ENABLE_0: begin
                    next_st.event_irq_enable_0 = bus.wdata & meim_pkg::EVENT_IRQ_ENABLE_0_IMPL;
                end
                meim_pkg::IDX_PULSE_MODE: begin
                    next_st.pulse_mode_reg = bus.wdata & meim_pkg::PULSE_MODE_IMPL;
                end
                meim_pkg::IDX_ACCUM_MODE: begin
                    next_st.accumulation_mode_reg = bus.wdata & meim_pkg::ACCUM_MODE_IMPL;
                end
                meim_pkg::IDX_RUN: begin
                    next_st.run = bus.wdata[0];
                    if (bus.wdata[0]) begin
                        next_st.crc_ref = cfg_checksum;
                    end
                end
                default: begin
                    next_st.run = st.run;
                end
            endcase
        end
        // request follows the registered flags, so it rises one cycle after the last clear
        next_st.irq_n = !(|pending);
        // a disabled pin idles high; the event path above is not affected
        next_st.pulse_pin = pulse_raw_n |
                            st.pulse_mode_reg[meim_pkg::PM_DIS_LSB +: 3];
    end

    assign irq_request_n = st.irq_n;
    assign pulse_out_first = st.pulse_pin[0];
    assign pulse_out_second = st.pulse_pin[1];
    assign pulse_out_third = st.pulse_pin[2];
    assign pulse_first_power_sel = st.pulse_mode_reg[meim_pkg::PM_SEL1_LSB +: 3];
    assign pulse_second_power_sel = st.pulse_mode_reg[meim_pkg::PM_SEL2_LSB +: 3];
    assign pulse_third_power_sel = st.pulse_mode_reg[meim_pkg::PM_SEL3_LSB +: 3];

    // single state register
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            st <= '0;
            st.status <= meim_pkg::STATUS_RST;
            st.event_irq_enable_0 <= meim_pkg::EVENT_IRQ_ENABLE_0_RST;
            st.pulse_mode_reg <= meim_pkg::PULSE_MODE_RST;
            st.accumulation_mode_reg <= meim_pkg::ACCUM_MODE_RST;
            st.irq_n <= 1'b1;
            st.pulse_pin <= 3'h7;
        end else begin
            st <= next_st;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    sequence s_status_w1c_dsp;
        wr_status && bus.wdata[meim_pkg::EB_DSP] && !dsp_pass_done;
    endsequence

    sequence s_run_started;
        bus.wr && (bus.idx == meim_pkg::IDX_RUN) && bus.wdata[0];
    endsequence

    a_peak_flag_value: assert property (
        volt_peak_period_done |=> st.status[meim_pkg::EB_PEAK_V] &&
                                   st.volt_peak_value_reg == $past(volt_peak_value))
        else $error("peak flag or peak value not captured");

    a_crc_after_run: assert property (
        s_run_started ##1 (cfg_checksum != $past(cfg_checksum)) |=>
            st.status[meim_pkg::EB_CRC])
        else $error("checksum mismatch not flagged");

    a_status_rsvd_zero: assert property (
        st.status[31:26] == 6'h00 && !st.status[meim_pkg::EB_RSVD])
        else $error("reserved status bits not zero");

    a_mask_bit2_inert: assert property (
        (st.event_irq_enable_0 == 32'h0000_0004) |=> irq_request_n)
        else $error("mask bit 2 raised the interrupt");

    a_line_mode_gate: assert property (
        line_cycle_done && st.accumulation_mode_reg[meim_pkg::AM_LINE_MODE] |=>
            st.status[meim_pkg::EB_LINE])
        else $error("line cycle done not flagged");

    a_pulse_fall_flag: assert property (
        $fell(pulse_raw_n[0]) && !$past(reset) |=> st.status[meim_pkg::EB_PULSE])
        else $error("pulse fall not flagged");

    a_pulse_pin_off: assert property (
        st.pulse_mode_reg[meim_pkg::PM_DIS_LSB] |=> pulse_out_first)
        else $error("disabled pulse pin not idle high");

    a_dsp_flag_set: assert property (
        dsp_pass_done |=> st.status[meim_pkg::EB_DSP])
        else $error("dsp done not flagged");

    a_irq_low_pending: assert property (
        (|pending) |=> !irq_request_n)
        else $error("pending event without interrupt");

    a_irq_release: assert property (
        !(|pending) [*2] |-> irq_request_n)
        else $error("interrupt held with nothing pending");

    a_w1c_clears: assert property (
        s_status_w1c_dsp |=> !st.status[meim_pkg::EB_DSP])
        else $error("write one did not clear flag");
endmodule

// file: hdl/meim_pkg.sv
package meim_pkg;
    // register indices; byte address is four times the index
    localparam logic [15:0] IDX_STATUS     = 16'he500;
    localparam logic [15:0] IDX_EVENT_IRQ_ENABLE_0      = 16'he50a;
    localparam logic [15:0] IDX_PULSE_MODE = 16'he510;
    localparam logic [15:0] IDX_ACCUM_MODE = 16'he511;
    localparam logic [15:0] IDX_RUN        = 16'he512;
    localparam logic [15:0] IDX_VOLT_PEAK_VALUE_REG      = 16'he513;
    localparam logic [15:0] IDX_NONE       = 16'hffff;

    // event bit positions, shared by status and mask
    localparam int unsigned EB_TOTAL_ACT  = 0;
    localparam int unsigned EB_FUND_ACT   = 1;
    localparam int unsigned EB_RSVD       = 2;
    localparam int unsigned EB_FUND_REACT = 3;
    localparam int unsigned EB_APPARENT   = 4;
    localparam int unsigned EB_LINE       = 5;
    localparam int unsigned EB_ACT_SIGN   = 6;
    localparam int unsigned EB_SUM1       = 9;
    localparam int unsigned EB_REACT_SIGN = 10;
    localparam int unsigned EB_SUM2       = 13;
    localparam int unsigned EB_PULSE      = 14;
    localparam int unsigned EB_DSP        = 17;
    localparam int unsigned EB_PEAK_V     = 24;
    localparam int unsigned EB_CRC        = 25;

    // pulse mode and accumulation mode fields
    localparam int unsigned PM_SEL1_LSB  = 0;
    localparam int unsigned PM_SEL2_LSB  = 3;
    localparam int unsigned PM_SEL3_LSB  = 6;
    localparam int unsigned PM_DIS_LSB   = 9;
    localparam int unsigned AM_SIGN_SEL  = 6;
    localparam int unsigned AM_LINE_MODE = 7;

    // implemented bits and reset values
    localparam logic [31:0] STATUS_IMPL     = 32'h0303_fffb;
    localparam logic [31:0] EVENT_IRQ_ENABLE_0_IMPL      = 32'h0003_ffff;
    localparam logic [31:0] EVENT_IRQ_ENABLE_0_IRQ       = 32'h0003_fffb;
    localparam logic [31:0] PULSE_MODE_IMPL = 32'h0000_0fff;
    localparam logic [31:0] ACCUM_MODE_IMPL = 32'h0000_00c0;
    localparam logic [31:0] STATUS_RST      = 32'h0000_0000;
    localparam logic [31:0] EVENT_IRQ_ENABLE_0_RST       = 32'h0000_0000;
    localparam logic [31:0] PULSE_MODE_RST  = 32'h0000_0000;
    localparam logic [31:0] ACCUM_MODE_RST  = 32'h0000_0000;

    // word index of an aligned byte address inside the 18-bit window
    function automatic logic [15:0] idx_of(input logic [19:0] addr);
        if (addr[1:0] != 2'h0 || addr[19:18] != 2'h0) begin
            return IDX_NONE;
        end
        return addr[17:2];
    endfunction
endpackage

// file: hdl/meim_reg_if.sv
`timescale 1ns/1ps
interface meim_reg_if;
    logic [15:0] idx;
    logic [31:0] wdata;
    logic        wr;
    logic        hit;
    logic [31:0] rdata;

    modport front (output idx, output wdata, output wr, input hit, input rdata);
    modport regs  (input idx, input wdata, input wr, output hit, output rdata);
endinterface
